// File: design/rffch_pkg.sv
package rffch_pkg;
  // command codes
  localparam logic [7:0] CMD_FAST_INV   = 8'hC1;
  localparam logic [7:0] CMD_FAST_INIT  = 8'hC2;
  localparam logic [7:0] CMD_FAST_RDMB  = 8'hC3;
  // error codes
  localparam logic [7:0] ERR_OPTION     = 8'h03;
  localparam logic [7:0] ERR_BLOCK_ADDR = 8'h10;
  localparam logic [7:0] ERR_READ_PROT  = 8'h15;
  // response flag bytes
  localparam logic [7:0] RSP_FLAGS_OK   = 8'h00;
  localparam logic [7:0] RSP_FLAGS_ERR  = 8'h01;
  // request flag bit positions
  localparam int FLG_SUBCARRIER = 0;
  localparam int FLG_INVENTORY  = 2;
  localparam int FLG_PROT_EXT   = 3;
  localparam int FLG_SELECT     = 4;
  localparam int FLG_AFI        = 4;
  localparam int FLG_ADDRESS    = 5;
  localparam int FLG_ONE_SLOT   = 5;
  localparam int FLG_OPTION     = 6;
  // request lengths in bits, crc included except in LEN_HDR; mask length limits
  localparam logic [7:0] LEN_HDR       = 8'd24;
  localparam logic [7:0] LEN_INIT      = 8'd40;
  localparam logic [7:0] LEN_RDMB      = 8'd64;
  localparam logic [7:0] LEN_RDMB_ADDR = 8'd128;
  localparam logic [7:0] RX_MAX_BITS   = 8'd128;
  localparam logic [7:0] MASK_MAX_ONE  = 8'd64;
  localparam logic [7:0] MASK_MAX_16   = 8'd60;
  // memory geometry
  localparam logic [15:0] NUM_BLOCKS   = 16'd2048;
  localparam int          SECTOR_SHIFT = 5;
  // crc
  localparam logic [15:0] CRC_INIT     = 16'hFFFF;
  localparam logic [15:0] CRC_POLY     = 16'h8408;
  localparam logic [15:0] CRC_RESIDUE  = 16'hF0B8;
  // link edges counted down after request end; the reply frame rises two edges later
  localparam logic [3:0] RESP_DELAY_EDGES = 4'd4;
  // register map and reset values
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STORAGE_FORMAT_IDENTIFIER  = 8'h04;
  localparam logic [7:0] REG_UID_LO = 8'h08;
  localparam logic [7:0] REG_UID_HI = 8'h0C;
  localparam logic [7:0] REG_AFI    = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam int CTRL_BUSY_MODE = 0;
  localparam int CTRL_READY     = 1;
  localparam logic [1:0]  CTRL_RST  = 2'h3;
  localparam logic [7:0]  STORAGE_FORMAT_IDENTIFIER_RST = 8'h00;
  localparam logic [7:0]  AFI_RST   = 8'h00;
  localparam logic [63:0] UID_RST   = 64'h0;
  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_RX    = 6'b000010,
    ST_EXEC  = 6'b000100,
    ST_CHECK = 6'b001000,
    ST_WAIT  = 6'b010000,
    ST_TX    = 6'b100000
  } rffch_state_t;

  typedef enum logic [7:0] {
    PH_FLAGS = 8'b00000001,
    PH_ERR   = 8'b00000010,
    PH_STORAGE_FORMAT_IDENTIFIER = 8'b00000100,
    PH_UID   = 8'b00001000,
    PH_SSS   = 8'b00010000,
    PH_DATA  = 8'b00100000,
    PH_CRC   = 8'b01000000,
    PH_END   = 8'b10000000
  } rffch_txph_t;
endpackage

// File: design/rffch_crc16.sv
`timescale 1ns/100ps
`default_nettype none
module rffch_crc16 (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        crc_clear,
  input  wire logic        crc_shift,
  input  wire logic        crc_bit,
  output logic      [15:0] crc_reg,
  output logic      [15:0] crc_next
);
  import rffch_pkg::*;

  // reflected form, bits taken lsb first as they travel on the air
  wire fb = crc_reg[0] ^ crc_bit;
  assign crc_next = fb ? ((crc_reg >> 1) ^ CRC_POLY) : (crc_reg >> 1);

  always_ff @(posedge aclk) begin
    if (!aresetn || crc_clear) begin
      crc_reg <= CRC_INIT;
    end else if (crc_shift) begin
      crc_reg <= crc_next;
    end
  end
endmodule
`default_nettype wire

// File: design/rffch_fast_cmd.sv
// What this block does
// - fast inventory gets no reply unless the session flag is armed
// - subcarrier flag set on a fast command yields an error reply
// - fast inventory runs anticollision; inventory flag must be one
// - fast command replies go out at double data rate
// - inventory request: flags, C1h, maker, optional filter, mask, crc
// - a faulty fast inventory request gets no reply, except the subcarrier error
// - inventory and initiate replies: flags, format id, uid, crc
// - busy mode holds activity low through inventory until reply
// - write-progress mode leaves the activity pin undriven
// - fast initiate arms the session flag; replies only when ready
// - fast initiate must be non-addressed; only the subcarrier error gets an answer
// - session flag clears on power loss
// - fast initiate request: flags, C2h, maker code, crc
// - busy mode drives activity low from request start to reply end
// - multi-block read returns 32 bits per block; count is n-1
// - at most 32 blocks, one sector; crossing gives an error
// - extension flag must be one for reads, else error code
// - read request: flags, C3h, maker, opt uid, block, count, crc
// - option flag puts a security byte before every data word
// - security byte: lock bit 0, protection, password, top zero
// - read errors: 03h option, 10h address, 15h read protected
`timescale 1ns/100ps
`default_nettype none
module rffch_fast_cmd #(
  parameter logic [7:0] MFG_CODE = 8'h5A  // arbitrary value
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        rf_link_clk,
  input  wire logic        rf_rx_frame,
  input  wire logic        rf_rx_data,
  output logic             rf_tx_frame,
  output logic             rf_tx_data,
  output logic             rf_tx_fast,
  output logic             rf_activity_output,
  output logic             rf_activity_output_oe,
  output logic      [10:0] mem_rd_addr,
  input  wire logic [31:0] mem_rd_data,
  input  wire logic        sector_lock,
  input  wire logic [1:0]  sector_rw_prot,
  input  wire logic [1:0]  sector_pwd_ctrl,
  input  wire logic        sector_read_denied
);
  import rffch_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [1:0]   ctrl_reg;
  logic [7:0]   storage_format_identifier_reg;
  logic [63:0]  uid_reg;
  logic [7:0]   afi_reg;
  logic         session_reg;
  logic         busy_reg;
  logic         inv_pend_reg;
  logic [3:0]   slot_reg;
  logic [3:0]   inv_slot_reg;
  logic [2:0]   lk_sync_reg;
  logic [1:0]   fr_sync_reg;
  logic [1:0]   dt_sync_reg;
  logic         fr_prev_reg;
  logic [127:0] rx_buf;
  logic [7:0]   rx_cnt_reg;
  logic         rx_ovf_reg;
  logic         rsp_err_reg;
  logic [7:0]   rsp_code_reg;
  logic         rsp_uid_reg;
  logic         rsp_opt_reg;
  logic [4:0]   blk_left_reg;
  logic [3:0]   dly_reg;
  logic [63:0]  tx_sr_reg;
  logic [6:0]   tx_left_reg;
  logic         aw_full_reg;
  logic         w_full_reg;
  logic [7:0]   aw_addr_reg;
  logic [31:0]  w_data_reg;
  logic [3:0]   w_strb_reg;
  logic [15:0]  rx_crc;
  logic [15:0]  tx_crc_next;
  logic [63:0]  nx_val;
  logic [6:0]   nx_len;
  rffch_state_t state_reg;
  rffch_state_t state_next;
  rffch_txph_t  ph_reg;
  rffch_txph_t  nx_ph;

  function automatic logic [31:0] apply_strb(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = data[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic reg_hit(input logic [7:0] a);
    return a == REG_CTRL || a == REG_STORAGE_FORMAT_IDENTIFIER || a == REG_UID_LO ||
           a == REG_UID_HI || a == REG_AFI || a == REG_STATUS;
  endfunction

  function automatic logic [31:0] reg_word(input logic [7:0] a);
    logic [31:0] w;
    unique case (a)
      REG_CTRL:   w = {30'h0, ctrl_reg};
      REG_STORAGE_FORMAT_IDENTIFIER:  w = {24'h0, storage_format_identifier_reg};
      REG_UID_LO: w = uid_reg[31:0];
      REG_UID_HI: w = uid_reg[63:32];
      REG_AFI:    w = {24'h0, afi_reg};
      REG_STATUS: w = {24'h0, slot_reg, 1'b0, inv_pend_reg, busy_reg,
                       session_reg};
      default:    w = 32'h0;
    endcase
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave: address and data taken in either order
  wire wr_go = aw_full_reg & w_full_reg & ~s_axi_bvalid;
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire aw_full_next = (aw_full_reg | aw_take) & ~wr_go;
  wire w_full_next = (w_full_reg | w_take) & ~wr_go;
  wire bvalid_next = (s_axi_bvalid & ~s_axi_bready) | wr_go;
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire rvalid_next = (s_axi_rvalid & ~s_axi_rready) | ar_take;
  wire [31:0] wr_merged = apply_strb(reg_word(aw_addr_reg), w_data_reg,
                                     w_strb_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= AXI_OKAY;
      s_axi_rdata <= 32'h0;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      s_axi_awready <= ~aw_full_next & ~bvalid_next;
      s_axi_wready <= ~w_full_next & ~bvalid_next;
      s_axi_bvalid <= bvalid_next;
      s_axi_arready <= ~rvalid_next;
      s_axi_rvalid <= rvalid_next;
      if (wr_go) begin
        s_axi_bresp <= reg_hit(aw_addr_reg) ? AXI_OKAY : AXI_SLVERR;
      end
      if (ar_take) begin
        s_axi_rdata <= reg_word(s_axi_araddr);
        s_axi_rresp <= reg_hit(s_axi_araddr) ? AXI_OKAY : AXI_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (aw_take) begin
      aw_addr_reg <= s_axi_awaddr;
    end
    if (w_take) begin
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end
  end

  // status register is read-only; writes to it are acknowledged and dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CTRL_RST;
      storage_format_identifier_reg <= STORAGE_FORMAT_IDENTIFIER_RST;
      uid_reg <= UID_RST;
      afi_reg <= AFI_RST;
    end else if (wr_go) begin
      unique case (aw_addr_reg)
        REG_CTRL:   ctrl_reg <= wr_merged[1:0];
        REG_STORAGE_FORMAT_IDENTIFIER:  storage_format_identifier_reg <= wr_merged[7:0];
        REG_UID_LO: uid_reg[31:0] <= wr_merged;
        REG_UID_HI: uid_reg[63:32] <= wr_merged;
        REG_AFI:    afi_reg <= wr_merged[7:0];
        default:    ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link sampling; the first stage of each pair feeds only the second
  wire lk_rise = lk_sync_reg[1] & ~lk_sync_reg[2];
  wire fr_s = fr_sync_reg[1];
  wire rx_sof = lk_rise & fr_s & ~fr_prev_reg;
  wire rx_eof = lk_rise & ~fr_s & fr_prev_reg;
  wire rx_bit = lk_rise & fr_s & fr_prev_reg & (state_reg == ST_RX);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lk_sync_reg <= 3'h0;
      fr_sync_reg <= 2'h0;
      dt_sync_reg <= 2'h0;
      fr_prev_reg <= 1'b0;
    end else begin
      lk_sync_reg <= {lk_sync_reg[1:0], rf_link_clk};
      fr_sync_reg <= {fr_sync_reg[0], rf_rx_frame};
      dt_sync_reg <= {dt_sync_reg[0], rf_rx_data};
      if (lk_rise) begin
        fr_prev_reg <= fr_s;
      end
    end
  end

  // oversize frames are flagged rather than wrapped, so they fail decode
  always_ff @(posedge aclk) begin
    if (!aresetn || rx_sof) begin
      rx_cnt_reg <= 8'h0;
      rx_ovf_reg <= 1'b0;
    end else if (rx_bit) begin
      if (rx_cnt_reg == RX_MAX_BITS) begin
        rx_ovf_reg <= 1'b1;
      end else begin
        rx_buf[rx_cnt_reg[6:0]] <= dt_sync_reg[1];
        rx_cnt_reg <= rx_cnt_reg + 8'd1;
      end
    end
  end

  rffch_crc16 u_rx_crc (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .crc_clear (rx_sof),
    .crc_shift (rx_bit),
    .crc_bit   (dt_sync_reg[1]),
    .crc_reg   (rx_crc),
    .crc_next  ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // request decode
  wire [7:0] rq_flags = rx_buf[7:0];
  wire [7:0] rq_cmd = rx_buf[15:8];
  wire rq_empty = rx_cnt_reg == 8'h0;
  wire hdr_ok = rx_crc == CRC_RESIDUE && rx_buf[23:16] == MFG_CODE &&
                rx_cnt_reg >= LEN_HDR && !rx_ovf_reg;
  wire sub_err = rq_flags[FLG_SUBCARRIER];
  wire marker = rq_empty & inv_pend_reg;
  wire marker_hit = marker & (inv_slot_reg == slot_reg + 4'd1);

  wire inv_cmd = hdr_ok && rq_cmd == CMD_FAST_INV && session_reg;
  wire [7:0] inv_ofs = rq_flags[FLG_AFI] ? 8'd32 : 8'd24;
  wire [127:0] inv_sh = rx_buf >> inv_ofs;
  wire [7:0] inv_mlen = inv_sh[7:0];
  wire [8:0] inv_mround = ({1'b0, inv_mlen} + 9'd7) & 9'h1F8;
  wire [8:0] inv_len = {1'b0, inv_ofs} + 9'd24 + inv_mround;
  wire [63:0] inv_mask = inv_mlen[6] ? ~64'h0 :
                         (64'h1 << inv_mlen[5:0]) - 64'h1;
  wire [63:0] uid_sh = uid_reg >> inv_mlen;
  wire one_slot = rq_flags[FLG_ONE_SLOT];
  wire inv_mlen_ok = one_slot ? inv_mlen <= MASK_MAX_ONE :
                                inv_mlen <= MASK_MAX_16;
  wire inv_afi_ok = !rq_flags[FLG_AFI] || rx_buf[31:24] == 8'h00 ||
                    rx_buf[31:24] == afi_reg;
  wire inv_valid = rq_flags[FLG_INVENTORY] && inv_len == {1'b0, rx_cnt_reg}
                   && inv_mlen_ok && inv_afi_ok &&
                   ((uid_reg ^ inv_sh[71:8]) & inv_mask) == 64'h0;
  wire inv_err = inv_cmd & sub_err;
  wire inv_ok = inv_cmd & ~sub_err & inv_valid;
  wire inv_now = inv_ok & (one_slot | uid_sh[3:0] == 4'h0);
  wire pend_next = (inv_ok & ~inv_now) |
                   (inv_pend_reg & ~marker_hit & ~inv_ok);

  wire init_cmd = hdr_ok && rq_cmd == CMD_FAST_INIT;
  wire init_err = init_cmd & sub_err;
  wire init_ok = init_cmd && !sub_err && rx_cnt_reg == LEN_INIT &&
                 !rq_flags[FLG_SELECT] && !rq_flags[FLG_ADDRESS];
  wire init_reply = init_ok & ctrl_reg[CTRL_READY];

  wire rd_amode = rq_flags[FLG_ADDRESS];
  wire [15:0] rd_first = rd_amode ? rx_buf[103:88] : rx_buf[39:24];
  wire [7:0] rd_cnt = rd_amode ? rx_buf[111:104] : rx_buf[47:40];
  wire [16:0] rd_last = {1'b0, rd_first} + {9'h0, rd_cnt};
  wire rd_cross = rd_last[16:SECTOR_SHIFT] !=
                  {1'b0, rd_first[15:SECTOR_SHIFT]};
  wire rd_cmd = hdr_ok && rq_cmd == CMD_FAST_RDMB &&
                rx_cnt_reg == (rd_amode ? LEN_RDMB_ADDR : LEN_RDMB) &&
                (!rd_amode || rx_buf[87:24] == uid_reg);
  wire rd_opt_bad = sub_err | ~rq_flags[FLG_PROT_EXT];
  wire rd_range_bad = rd_first >= NUM_BLOCKS || rd_cross;
  wire rd_err = rd_cmd & (rd_opt_bad | rd_range_bad);
  wire rd_go = rd_cmd & ~rd_err;

  wire ex_err = inv_err | init_err | rd_err;
  wire [7:0] ex_code = (rd_cmd & ~rd_opt_bad) ? ERR_BLOCK_ADDR
                                               : ERR_OPTION;
  wire ex_uid = inv_now | init_reply | marker_hit;
  wire ex_reply = ex_err | ex_uid;

  ////////////////////////////////////////////////////////////////////////////
  // control sequence
  wire in_exec = state_reg == ST_EXEC;
  wire wait_done = state_reg == ST_WAIT && lk_rise && dly_reg == 4'h0;
  wire tx_edge = state_reg == ST_TX && lk_rise;
  wire tx_end = tx_edge && ph_reg == PH_END;
  wire tx_load = tx_edge && ph_reg != PH_END && tx_left_reg == 7'd1;
  wire tx_crc_en = tx_edge && ph_reg != PH_END && ph_reg != PH_CRC;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:  if (rx_sof) state_next = ST_RX;
      ST_RX:    if (rx_eof) state_next = ST_EXEC;
      ST_EXEC:  state_next = rd_go ? ST_CHECK :
                             ex_reply ? ST_WAIT : ST_IDLE;
      ST_CHECK: state_next = ST_WAIT;
      ST_WAIT:  if (wait_done) state_next = ST_TX;
      ST_TX:    if (tx_end) state_next = ST_IDLE;
      default:  state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      session_reg <= 1'b0;
      inv_pend_reg <= 1'b0;
      slot_reg <= 4'h0;
      inv_slot_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      if (in_exec && init_ok) begin
        session_reg <= 1'b1;
      end
      if (in_exec) begin
        inv_pend_reg <= pend_next;
      end
      if (in_exec && inv_ok) begin
        slot_reg <= 4'h0;
        inv_slot_reg <= uid_sh[3:0];
      end else if (in_exec && marker) begin
        slot_reg <= slot_reg + 4'd1;
      end
    end
  end

  // busy spans request start to reply end; an unanswered slot keeps it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_reg <= 1'b0;
      rf_activity_output <= 1'b1;
      rf_activity_output_oe <= 1'b0;
    end else begin
      if (state_reg == ST_IDLE && rx_sof) begin
        busy_reg <= 1'b1;
      end else if (in_exec && !ex_reply && !rd_go) begin
        busy_reg <= pend_next;
      end else if (tx_end) begin
        busy_reg <= inv_pend_reg;
      end
      rf_activity_output <= ~(busy_reg & ctrl_reg[CTRL_BUSY_MODE]);
      rf_activity_output_oe <= ctrl_reg[CTRL_BUSY_MODE];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rsp_err_reg <= 1'b0;
      rsp_code_reg <= ERR_OPTION;
      rsp_uid_reg <= 1'b0;
      rsp_opt_reg <= 1'b0;
      dly_reg <= RESP_DELAY_EDGES;
    end else if (in_exec) begin
      rsp_err_reg <= ex_err;
      rsp_code_reg <= ex_code;
      rsp_uid_reg <= ex_uid;
      rsp_opt_reg <= rq_flags[FLG_OPTION];
      dly_reg <= RESP_DELAY_EDGES;
    end else if (state_reg == ST_CHECK && sector_read_denied) begin
      rsp_err_reg <= 1'b1;
      rsp_code_reg <= ERR_READ_PROT;
    end else if (state_reg == ST_WAIT && lk_rise) begin
      dly_reg <= dly_reg - 4'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reply serialiser, fields lsb first, next field loaded with last bit
  always_comb begin
    nx_ph = PH_END;
    unique case (ph_reg)
      PH_FLAGS: nx_ph = rsp_err_reg ? PH_ERR : rsp_uid_reg ? PH_STORAGE_FORMAT_IDENTIFIER :
                        rsp_opt_reg ? PH_SSS : PH_DATA;
      PH_STORAGE_FORMAT_IDENTIFIER: nx_ph = PH_UID;
      PH_SSS:   nx_ph = PH_DATA;
      PH_DATA:  nx_ph = blk_left_reg == 5'h0 ? PH_CRC :
                        rsp_opt_reg ? PH_SSS : PH_DATA;
      PH_ERR, PH_UID: nx_ph = PH_CRC;
      PH_CRC, PH_END: nx_ph = PH_END;
    endcase
  end

  always_comb begin
    nx_val = 64'h0;
    nx_len = 7'd8;
    unique case (nx_ph)
      PH_ERR:   nx_val = {56'h0, rsp_code_reg};
      PH_STORAGE_FORMAT_IDENTIFIER: nx_val = {56'h0, storage_format_identifier_reg};
      PH_SSS:   nx_val = {59'h0, sector_pwd_ctrl, sector_rw_prot,
                          sector_lock};
      PH_UID: begin
        nx_val = uid_reg;
        nx_len = 7'd64;
      end
      PH_DATA: begin
        nx_val = {32'h0, mem_rd_data};
        nx_len = 7'd32;
      end
      PH_CRC: begin
        nx_val = {48'h0, ~tx_crc_next};
        nx_len = 7'd16;
      end
      PH_FLAGS, PH_END: nx_len = 7'd1;
    endcase
  end

  rffch_crc16 u_tx_crc (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .crc_clear (state_reg == ST_WAIT),
    .crc_shift (tx_crc_en),
    .crc_bit   (tx_sr_reg[0]),
    .crc_reg   (),
    .crc_next  (tx_crc_next)
  );

  // one bit per link edge: twice the rate of a normal reply
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rf_tx_frame <= 1'b0;
      rf_tx_data <= 1'b0;
      rf_tx_fast <= 1'b0;
      ph_reg <= PH_END;
      tx_left_reg <= 7'h0;
    end else if (wait_done) begin
      ph_reg <= PH_FLAGS;
      tx_sr_reg <= {56'h0, rsp_err_reg ? RSP_FLAGS_ERR : RSP_FLAGS_OK};
      tx_left_reg <= 7'd8;
    end else if (tx_end) begin
      rf_tx_frame <= 1'b0;
      rf_tx_fast <= 1'b0;
    end else if (tx_edge) begin
      rf_tx_frame <= 1'b1;
      rf_tx_fast <= 1'b1;
      rf_tx_data <= tx_sr_reg[0];
      if (tx_load) begin
        ph_reg <= nx_ph;
        tx_sr_reg <= nx_val;
        tx_left_reg <= nx_len;
      end else begin
        tx_sr_reg <= tx_sr_reg >> 1;
        tx_left_reg <= tx_left_reg - 7'd1;
      end
    end
  end

  // block walk stays inside one sector, so the security inputs hold
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem_rd_addr <= 11'h0;
      blk_left_reg <= 5'h0;
    end else if (in_exec && rd_go) begin
      mem_rd_addr <= rd_first[10:0];
      blk_left_reg <= rd_cnt[4:0];
    end else if (tx_load && nx_ph == PH_DATA) begin
      mem_rd_addr <= mem_rd_addr + 11'd1;
      if (ph_reg == PH_DATA) begin
        blk_left_reg <= blk_left_reg - 5'd1;
      end
    end else if (tx_load && ph_reg == PH_DATA && nx_ph == PH_SSS) begin
      blk_left_reg <= blk_left_reg - 5'd1;
    end
  end
endmodule
`default_nettype wire

// File: verif/rffch_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module rffch_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic rf_tx_frame,
  input wire logic rf_tx_fast,
  input wire logic rf_activity_output,
  input wire logic rf_activity_output_oe
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_fast_rate: assert property (rf_tx_fast == rf_tx_frame)
    else $error("reply not fast");
  a_busy_reply: assert property (
    rf_tx_frame && rf_activity_output_oe |-> !rf_activity_output)
    else $error("pin high in reply");
  a_pin_undriven: assert property (
    !rf_activity_output |-> rf_activity_output_oe) else $error("low undriven");
  a_quiet_start: assert property (
    $rose(aresetn) |-> !rf_tx_frame ##1 !rf_tx_frame) else $error("reply early");
  a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer lost");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read answer lost");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_reply_len: assert property (
    $rose(rf_tx_frame) |-> rf_tx_frame[*8]) else $error("reply cut short");
endmodule
bind rffch_fast_cmd rffch_monitor u_mon (.*);
`default_nettype wire

// File: verif/rffch_reader.sv
`timescale 1ns/100ps
`default_nettype none
module rffch_reader (
  input  wire logic rf_tx_frame,
  input  wire logic rf_tx_data,
  output logic      rf_link_clk,
  output logic      rf_rx_frame,
  output logic      rf_rx_data
);
  logic [7:0] rsp[$];
  logic [7:0] acc;
  int         nb;
  initial {rf_link_clk, rf_rx_frame, rf_rx_data} = 3'b000;
  function automatic logic [15:0] crc(input logic [7:0] q[$]);
    logic [15:0] c = 16'hFFFF;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
    end
    return ~c;
  endfunction
  task automatic tick();
    #80 rf_link_clk = 1'b1;
    #80 rf_link_clk = 1'b0;
  endtask
  // clock runs only for a request and its reply window
  task automatic xfer(input logic [7:0] q[$]);
    logic [15:0] c = crc(q);
    q = {q, c[7:0], c[15:8]};
    rsp.delete();
    nb = 0;
    rf_rx_frame = 1'b1;
    tick();
    foreach (q[i]) for (int b = 0; b < 8; b++) begin
      rf_rx_data = q[i][b];
      tick();
    end
    rf_rx_frame = 1'b0;
    repeat (116) begin
      rf_rx_data = ~rf_rx_data;
      tick();
      if (rf_tx_frame) begin
        acc = {rf_tx_data, acc[7:1]};
        nb++;
        if (nb % 8 == 0) rsp.push_back(acc);
      end
    end
  endtask
endmodule
`default_nettype wire

// File: verif/rffch_fast_cmd_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module rffch_fast_cmd_tb_top;
  import rffch_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, rf_link_clk;
  logic        rf_rx_frame, rf_rx_data, rf_tx_frame, rf_tx_data, rf_tx_fast;
  logic        rf_activity_output, rf_activity_output_oe, sector_lock;
  logic        sector_read_denied, aw, wd, ar, dn;
  logic [1:0]  s_axi_bresp, s_axi_rresp, sector_rw_prot, sector_pwd_ctrl;
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, ex[$], q[$];
  logic [10:0] mem_rd_addr, ba;
  logic [31:0] s_axi_wdata, s_axi_rdata, mem_rd_data, lfsr, rdv;
  logic [47:0] tbl[6];
  int          n_fail, comparisons;
  rffch_fast_cmd u_dut (.*);
  rffch_reader   u_rdr (.*);
  assign mem_rd_data = {mem_rd_addr, 5'h0A, mem_rd_addr, 5'h15};
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  initial begin
    #500000;
    n_fail++;
    final_report();
  end
  task automatic chk(input string nm, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
    {s_axi_arvalid, s_axi_rready} <= {2{!w}};
    dn = 1'b0;
    for (int t = 0; t < 40 && !dn; t++) begin
      @(negedge aclk);
      {aw, wd, ar, rdv} = {s_axi_awready, s_axi_wready, s_axi_arready, s_axi_rdata};
      dn = w ? s_axi_bvalid : s_axi_rvalid;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (wd) s_axi_wvalid <= 1'b0;
      if (ar) s_axi_arvalid <= 1'b0;
    end
    {s_axi_bready, s_axi_rready} <= 2'b00;
  endtask
  // ex holds the expected reply bytes, empty for silence
  task automatic rf(input string nm, input logic u);
    logic [15:0] c;
    if (u) ex = {8'h00, 8'h3C, lfsr[7:0], lfsr[15:8], lfsr[23:16], lfsr[31:24],
      8'h00, 8'h00, 8'h00, 8'h00};
    c = u_rdr.crc(ex);
    if (ex.size() > 0) ex = {ex, c[7:0], c[15:8]};
    u_rdr.xfer(q);
    chk(nm, 32'(u_rdr.rsp.size()), 32'(ex.size()));
    foreach (ex[i]) chk(nm, u_rdr.rsp[i], ex[i]);
    $display("test %s done", nm);
    ex.delete();
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
    {s_axi_rready, sector_lock, sector_read_denied, aresetn} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {sector_rw_prot, sector_pwd_ctrl, s_axi_wstrb} = 8'h0F;
    {n_fail, comparisons, lfsr} = {32'h0, 32'h0, 32'h063CF823};
    tbl = '{48'h48_0040_01_00_00, 48'h40_0040_00_00_03, 48'h49_0040_00_00_03,
      48'h08_005F_01_00_10, 48'h08_0800_00_00_10, 48'h08_0040_00_01_15};
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    bus(0, REG_CTRL, 0);
    chk("ctrl", rdv, {30'h0, CTRL_RST});
    bus(0, 8'h40, 0);
    chk("unmapped", s_axi_rresp, AXI_SLVERR);
    bus(1, 8'h04, 32'h3C);
    bus(1, REG_UID_LO, lfsr);
    q = {8'h24, CMD_FAST_INV, 8'h5A, 8'h00};
    rf("inv_cold", 0);
    q = {8'h10, CMD_FAST_INIT, 8'h5A};
    rf("init_sel", 0);
    bus(1, REG_CTRL, 0);
    q[0] = 8'h00;
    rf("init_wait", 0);
    chk("pin_oe", rf_activity_output_oe, 0);
    bus(1, REG_CTRL, 3);
    q = {8'h24, CMD_FAST_INV, 8'h5A, 8'h00};
    rf("inv", 1);
    q = {8'h00, CMD_FAST_INIT, 8'h5A};
    rf("init", 1);
    q[0] = 8'h01;
    ex = {8'h01, ERR_OPTION};
    rf("init_sub", 0);
    foreach (tbl[k]) begin
      lfsr = {lfsr[30:0], ^(lfsr & 32'h80200003)};
      {sector_pwd_ctrl, sector_rw_prot, sector_lock} <= lfsr[4:0];
      sector_read_denied <= tbl[k][8];
      ex = {8'h00};
      if (tbl[k][7:0] != 8'h00) ex = {8'h01, tbl[k][7:0]};
      else for (int b = 0; b <= tbl[k][23:16]; b++) begin
        ba = 11'(tbl[k][34:24] + b);
        if (tbl[k][46]) ex.push_back({3'b000, lfsr[4:0]});
        rdv = {ba, 5'h0A, ba, 5'h15};
        ex = {ex, rdv[7:0], rdv[15:8], rdv[23:16], rdv[31:24]};
      end
      q = {tbl[k][47:40], CMD_FAST_RDMB, 8'h5A, tbl[k][31:24],
        tbl[k][39:32], tbl[k][23:16]};
      rf("read", 0);
    end
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    q = {8'h24, CMD_FAST_INV, 8'h5A, 8'h00};
    rf("inv_reset", 0);
    final_report();
  end
endmodule
`default_nettype wire
